// *** logic/ncr_decode.v ***
// Purpose: Non-cacheable block 2 decode, ROM chip select and IRQ1/IRQ12 latching
// Assumes: Host cycle qualifiers come from logic on clk_sys; IRQ pins are asynchronous
// Notes:   Registers on classic Wishbone, one 32-bit word per index
`timescale 1ns/10ps
`default_nettype none
`include "ncr_defs.vh"

////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - Size field: 64K,128K,256K,1M; top bit disables
// - Noncache_block2_size_high_addr bits 2:0 give A26:24
// - Noncache_block2_mid_addr holds A23:16 of start
// - Start bits below block size ignored
// - Index 2Ch not decoded, no store
// - IRQ12 latched when bit 7 clear
// - IRQ1 latched when bit 6 clear; port 60h read clears
// - Enabled ROM window read asserts chip select
// - Six bits map ascending 32KB windows
// - ROM writes need write-enable bit 7
module ncr_decode (
   // Clock, reset, enable
   input  wire        clk_sys,
   input  wire        reset_n,
   input  wire        clk_en,
   // Wishbone slave
   input  wire        wb_cyc_i,
   input  wire        wb_stb_i,
   input  wire        wb_we_i,
   input  wire [9:0]  wb_adr_i,
   input  wire [3:0]  wb_sel_i,
   input  wire [31:0] wb_dat_i,
   output reg  [31:0] wb_dat_o,
   output reg         wb_ack_o,
   output wire        wb_err_o,
   // Host cycle
   input  wire        host_cycle_valid,
   input  wire        host_mem_cycle,
   input  wire        host_write,
   input  wire [26:0] host_addr,
   // Decode results
   output wire        rom_chip_select_n,
   output wire        noncache_hit,
   output wire        l1_cache_disable,
   output wire        l2_cache_disable,
   // Interrupt requests
   input  wire        kbd_irq_in,
   input  wire        mouse_irq_in,
   output wire        kbd_irq_out,
   output wire        mouse_irq_out,
   output wire        irq
);

   ////////////////////////////////////////////////////////////////////////////
   // Registers
   reg  [7:0] size_hi_reg;
   reg  [7:0] mid_reg;
   reg  [7:0] rom_irq_reg;
   reg  [7:0] wr_ctrl_reg;
   reg  [3:0] status_reg;
   reg  [3:0] mask_reg;
   reg        kbd_latch_reg;
   reg        mouse_latch_reg;
   reg        kbd_prev_reg;
   reg        mouse_prev_reg;
   reg        rom_sel_reg;

   wire [1:0] irq_sync;
   wire [7:0] idx       = wb_adr_i[9:2];
   wire       wb_req    = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   wire       wb_wr     = wb_req & wb_we_i & wb_sel_i[0];
   wire       idx_known;

   ncr_sync2 #(.WIDTH(2)) u_sync (
      .clk_sys (clk_sys),
      .reset_n (reset_n),
      .clk_en  (clk_en),
      .d_async ({mouse_irq_in, kbd_irq_in}),
      .q_sync  (irq_sync)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Block 2 decode
   wire [2:0] size_fld = size_hi_reg[`NCR_SIZE_MSB:`NCR_SIZE_LSB];
   reg  [3:0] ign_mask;
   always @* begin
      case (size_fld[1:0])
         `NCR_SIZE_64K:  ign_mask = 4'h0;
         `NCR_SIZE_128K: ign_mask = 4'h1;
         `NCR_SIZE_256K: ign_mask = 4'h3;
         `NCR_SIZE_1M:   ign_mask = 4'hF;
         default:        ign_mask = 4'h0;
      endcase
   end

   wire [10:0] blk_start = {size_hi_reg[2:0], mid_reg};
   wire [10:0] cmp_mask  = {7'h7F, ~ign_mask};
   wire        blk_en    = ~size_fld[2];
   wire        blk_hit   = blk_en & host_cycle_valid & host_mem_cycle &
                           (((host_addr[26:16] ^ blk_start) & cmp_mask) == 11'h000);

   assign noncache_hit     = blk_hit;
   assign l1_cache_disable = blk_hit;
   assign l2_cache_disable = blk_hit;

   ////////////////////////////////////////////////////////////////////////////
   // ROM chip select
   wire [5:0] win_hit;
   genvar gi;
   generate
      for (gi = 0; gi < `NCR_ROM_WINDOWS; gi = gi + 1) begin : g_win
         // Window gi covers C0000h + gi*8000h
         localparam [4:0] WIN_BASE = `NCR_ROM_BASE_HI + gi;
         assign win_hit[gi] = rom_irq_reg[gi] & (host_addr[26:20] == 7'h00) &
                              (host_addr[19:15] == WIN_BASE);
      end
   endgenerate

   wire rom_cycle = host_cycle_valid & host_mem_cycle & (|win_hit);
   // Writes only select the ROM when flash updates are allowed
   wire rom_sel   = rom_cycle & (~host_write |
                    wr_ctrl_reg[`NCR_ROM_WR_EN_BIT]);
   assign rom_chip_select_n = ~rom_sel;

   ////////////////////////////////////////////////////////////////////////////
   // IRQ latching
   wire port60_rd = host_cycle_valid & ~host_mem_cycle & ~host_write &
                    (host_addr[15:0] == `NCR_KBD_DATA_PORT);
   wire kbd_rise   = irq_sync[0] & ~kbd_prev_reg;
   wire mouse_rise = irq_sync[1] & ~mouse_prev_reg;
   wire kbd_lat_en   = ~rom_irq_reg[`NCR_KBD_LATCH_BIT];
   wire mouse_lat_en = ~rom_irq_reg[`NCR_MOUSE_LATCH_BIT];

   assign kbd_irq_out   = kbd_lat_en ? kbd_latch_reg : irq_sync[0];
   assign mouse_irq_out = mouse_lat_en ? mouse_latch_reg : irq_sync[1];

   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         kbd_latch_reg   <= 1'b0;
         mouse_latch_reg <= 1'b0;
         kbd_prev_reg    <= 1'b0;
         mouse_prev_reg  <= 1'b0;
         rom_sel_reg     <= 1'b0;
      end else if (clk_en) begin
         kbd_prev_reg   <= irq_sync[0];
         mouse_prev_reg <= irq_sync[1];
         rom_sel_reg    <= rom_sel;
         // A new edge wins over the port 60h clear
         if (kbd_rise)
            kbd_latch_reg <= 1'b1;
         else if (port60_rd)
            kbd_latch_reg <= 1'b0;
         if (mouse_rise)
            mouse_latch_reg <= 1'b1;
         else if (port60_rd)
            mouse_latch_reg <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Interrupt status
   wire [3:0] events = {blk_hit, rom_sel & ~rom_sel_reg, mouse_rise, kbd_rise};
   assign irq = |(status_reg & mask_reg);

   ////////////////////////////////////////////////////////////////////////////
   // Register file
   assign idx_known = (idx == `NCR_IDX_BLK2_SIZE_HI) | (idx == `NCR_IDX_BLK2_MID) |
                      (idx == `NCR_IDX_ROM_IRQ) | (idx == `NCR_IDX_IRQ_STATUS) |
                      (idx == `NCR_IDX_IRQ_MASK) | (idx == `NCR_IDX_WR_CTRL);
   // Index 2Ch and other holes are acked with zero data; err is never raised
   assign wb_err_o = wb_ack_o ? 1'b0 : 1'b0;

   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         size_hi_reg <= `NCR_RST_BLK2_SIZE_HI;
         mid_reg     <= `NCR_RST_BLK2_MID;
         rom_irq_reg <= `NCR_RST_ROM_IRQ;
         wr_ctrl_reg <= `NCR_RST_WR_CTRL;
         mask_reg    <= 4'h0;
         status_reg  <= 4'h0;
         wb_ack_o    <= 1'b0;
         wb_dat_o    <= 32'h00000000;
      end else if (clk_en) begin
         wb_ack_o <= wb_req;
         wb_dat_o <= 32'h00000000;
         if (wb_wr && idx == `NCR_IDX_BLK2_SIZE_HI)
            size_hi_reg <= wb_dat_i[7:0];
         if (wb_wr && idx == `NCR_IDX_BLK2_MID)
            mid_reg <= wb_dat_i[7:0];
         if (wb_wr && idx == `NCR_IDX_ROM_IRQ)
            rom_irq_reg <= wb_dat_i[7:0];
         if (wb_wr && idx == `NCR_IDX_WR_CTRL)
            wr_ctrl_reg <= wb_dat_i[7:0];
         if (wb_wr && idx == `NCR_IDX_IRQ_MASK)
            mask_reg <= wb_dat_i[3:0];
         // Set wins over write-one-to-clear
         if (wb_wr && idx == `NCR_IDX_IRQ_STATUS)
            status_reg <= (status_reg & ~wb_dat_i[3:0]) | events;
         else
            status_reg <= status_reg | events;
         if (wb_req && !wb_we_i) begin
            case (idx)
               `NCR_IDX_BLK2_SIZE_HI: wb_dat_o <= {24'h000000, size_hi_reg};
               `NCR_IDX_BLK2_MID:     wb_dat_o <= {24'h000000, mid_reg};
               `NCR_IDX_ROM_IRQ:      wb_dat_o <= {24'h000000, rom_irq_reg};
               `NCR_IDX_WR_CTRL:      wb_dat_o <= {24'h000000, wr_ctrl_reg};
               `NCR_IDX_IRQ_STATUS:   wb_dat_o <= {28'h0000000, status_reg};
               `NCR_IDX_IRQ_MASK:     wb_dat_o <= {28'h0000000, mask_reg};
               default:               wb_dat_o <= 32'h00000000;
            endcase
         end
      end
   end

endmodule // ncr_decode

`default_nettype wire

// *** logic/ncr_sync2.v ***
// Purpose: Two flip-flop synchroniser for asynchronous levels
// Assumes: Destination runs on clk_sys
// Notes:   First stage feeds only the second stage
`timescale 1ns/10ps
`default_nettype none

module ncr_sync2 #(
   parameter WIDTH = 2
) (
   // Clock and reset
   input  wire             clk_sys,
   input  wire             reset_n,
   input  wire             clk_en,
   // Data
   input  wire [WIDTH-1:0] d_async,
   output reg  [WIDTH-1:0] q_sync
);

   reg [WIDTH-1:0] meta_reg;

   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         meta_reg <= {WIDTH{1'b0}};
         q_sync   <= {WIDTH{1'b0}};
      end else if (clk_en) begin
         meta_reg <= d_async;
         q_sync   <= meta_reg;
      end
   end

endmodule // ncr_sync2

`default_nettype wire

// *** pkg/ncr_defs.vh ***
// Purpose: Constants for the non-cacheable block 2 / ROM select / IRQ latch block
// Assumes: Wishbone byte addresses are four times the register index
// Notes:   Definitions only
`ifndef NCR_DEFS_VH
`define NCR_DEFS_VH

// Register indices
`define NCR_IDX_BLK2_SIZE_HI   8'h2A
`define NCR_IDX_BLK2_MID       8'h2B
`define NCR_IDX_UNDECODED      8'h2C
`define NCR_IDX_ROM_IRQ        8'h2D
`define NCR_IDX_IRQ_STATUS     8'h30
`define NCR_IDX_IRQ_MASK       8'h31
`define NCR_IDX_WR_CTRL        8'h32

// Reset values
`define NCR_RST_BLK2_SIZE_HI   8'hE0
`define NCR_RST_BLK2_MID       8'h00
`define NCR_RST_ROM_IRQ        8'hC0
`define NCR_RST_IRQ_MASK       8'h00
`define NCR_RST_WR_CTRL        8'h00

// Field positions
`define NCR_SIZE_MSB           7
`define NCR_SIZE_LSB           5
`define NCR_SIZE_DIS_BIT       7
`define NCR_MOUSE_LATCH_BIT    7
`define NCR_KBD_LATCH_BIT      6
`define NCR_ROM_WR_EN_BIT      7

// Size encodings
`define NCR_SIZE_64K           2'h0
`define NCR_SIZE_128K          2'h1
`define NCR_SIZE_256K          2'h2
`define NCR_SIZE_1M            2'h3

// Decode constants
`define NCR_KBD_DATA_PORT      16'h0060
`define NCR_ROM_BASE_HI        5'h18
`define NCR_ROM_WINDOWS        6

// Interrupt status bits
`define NCR_EV_KBD             0
`define NCR_EV_MOUSE           1
`define NCR_EV_ROM             2
`define NCR_EV_NC              3

`endif

// *** test/ncr_decode_assertions.sv ***
// Purpose: Port assertions for ncr_decode
// Assumes: Bound to every ncr_decode
// Notes:   Sees ports only
`timescale 1ns/10ps
`default_nettype none
module ncr_decode_chk (
   // Clock, reset, bus
   input wire logic        clk_sys, reset_n, clk_en, wb_cyc_i, wb_stb_i, wb_ack_o,
   // Host cycle, decode and keyboard IRQ
   input wire logic        host_cycle_valid, host_mem_cycle, host_write,
   input wire logic [26:0] host_addr,
   input wire logic        rom_chip_select_n, noncache_hit, l1_cache_disable,
   input wire logic        l2_cache_disable, kbd_irq_in, kbd_irq_out
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   wire io_cyc = host_cycle_valid && !host_mem_cycle;
   wire p60    = io_cyc && !host_write && host_addr[15:0] == 16'h0060;
   sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o && clk_en; endsequence
   // A read of the data port may clear the latch, so it is kept out
   sequence s_kbd; !kbd_irq_in ##1 (kbd_irq_in && clk_en && !p60) [*4]; endsequence
   a_ack_answers: assert property (s_req |=> wb_ack_o)
      else $error("ack missing");
   a_ack_single: assert property (wb_ack_o && clk_en |=> !wb_ack_o)
      else $error("ack too long");
   a_nc_caches: assert property (
      noncache_hit == l1_cache_disable && noncache_hit == l2_cache_disable) else $error("cache off");
   a_nc_io_miss: assert property (io_cyc |-> !noncache_hit)
      else $error("io hit");
   a_rom_io_off: assert property (io_cyc |-> rom_chip_select_n)
      else $error("rom on io");
   a_rom_out_range: assert property (
      host_addr < 27'h00C0000 || host_addr > 27'h00EFFFF |-> rom_chip_select_n) else $error("rom out");
   a_rom_reset_off: assert property ($rose(reset_n) |-> rom_chip_select_n)
      else $error("rom after reset");
   a_kbd_latch_set: assert property (s_kbd |-> kbd_irq_out)
      else $error("kbd not raised");
endmodule // ncr_decode_chk
////////////////////////////////////////
bind ncr_decode ncr_decode_chk chk_u (.clk_sys, .reset_n, .clk_en, .wb_cyc_i, .wb_stb_i,
   .wb_ack_o, .host_cycle_valid, .host_mem_cycle, .host_write, .host_addr, .rom_chip_select_n,
   .noncache_hit, .l1_cache_disable, .l2_cache_disable, .kbd_irq_in, .kbd_irq_out);
`default_nettype wire

// *** test/ncr_decode_tb.sv ***
// Purpose: Self-checking bench for ncr_decode
// Assumes: 20 MHz clk_sys
// Notes:   Scenarios run after one reset
`timescale 1ns/10ps
`default_nettype none
`include "ncr_defs.vh"
module ncr_decode_tb;
   logic        clk_sys = 1'b0, reset_n = 1'b0, cyc = 1'b0, we = 1'b0;
   logic [7:0]  idx = 8'h00, wd = 8'h00;
   logic [31:0] rdat;
   wire  [31:0] dat;
   wire  [26:0] ha;
   wire         ack, cs_n, nc, ko, mo, irq, hv, hm, hw, ki, mi;
   int          fail_count = 0, n_checks = 0;
   ncr_decode dut_u (.clk_sys, .reset_n, .clk_en(1'b1), .wb_cyc_i(cyc), .wb_stb_i(cyc),
      .wb_we_i(we), .wb_adr_i({idx, 2'b00}), .wb_sel_i(4'hF), .wb_dat_i({24'h000000, wd}),
      .wb_dat_o(dat), .wb_ack_o(ack), .wb_err_o(), .host_cycle_valid(hv), .host_mem_cycle(hm),
      .host_write(hw), .host_addr(ha), .rom_chip_select_n(cs_n), .noncache_hit(nc),
      .l1_cache_disable(), .l2_cache_disable(), .kbd_irq_in(ki), .mouse_irq_in(mi),
      .kbd_irq_out(ko), .mouse_irq_out(mo), .irq);
   ncr_host_model host_u (.clk_sys, .host_cycle_valid(hv), .host_mem_cycle(hm),
      .host_write(hw), .host_addr(ha), .kbd_irq(ki), .mouse_irq(mi));
   initial forever #25 clk_sys = ~clk_sys;
   ////////////////////////////////////////
   task automatic chk(string s, logic [31:0] e, logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         fail_count++;
         $display("unexpected %s: expected %0h, seen %0h", s, e, g);
      end
   endtask
   task automatic wb(logic w, logic [7:0] i, logic [7:0] d);
      cyc <= 1'b1;
      we <= w;
      idx <= i;
      wd <= d;
      do @(posedge clk_sys); while (ack !== 1'b1);
      rdat = dat;
      cyc <= 1'b0;
      @(posedge clk_sys);
   endtask
   task automatic rd(logic [7:0] i, logic [7:0] e);
      wb(1'b0, i, 8'h00);
      chk($sformatf("index %0h", i), {24'h000000, e}, rdat);
   endtask
   // Decode is combinational, so it is judged mid-cycle
   task automatic host(logic m, logic w, logic [26:0] a, logic c, logic n);
      host_u.host_on(m, w, a);
      @(negedge clk_sys);
      chk("rom_chip_select_n", c, cs_n);
      chk("noncache_hit", n, nc);
      @(posedge clk_sys);
      host_u.host_off();
      @(posedge clk_sys);
   endtask
   task automatic t_regs();
      rd(`NCR_IDX_BLK2_SIZE_HI, 8'hE0);
      rd(`NCR_IDX_ROM_IRQ, 8'hC0);
      wb(1, `NCR_IDX_UNDECODED, 8'h5A);
      rd(`NCR_IDX_UNDECODED, 8'h00);
      wb(1, `NCR_IDX_BLK2_MID, 8'hA5);
      rd(`NCR_IDX_BLK2_MID, 8'hA5);
      host(1, 0, 27'h00C0000, 1, 0);
   endtask
   task automatic t_block2();
      logic [26:0] b, s;
      b = 27'h5400000;
      for (int i = 0; i < 5; i++) begin
         s = 27'h0010000 << ((i == 3) ? 4 : i);
         wb(1, `NCR_IDX_BLK2_MID, 8'h40 | 8'(s[23:16] - 1));
         wb(1, `NCR_IDX_BLK2_SIZE_HI, {i[2:0], 5'h05});
         host(1, 0, b + s - 1, 1, i < 4);
         host(1, 1, b, 1, i < 4);
         host(1, 0, b - 1, 1, 0);
         host(1, 0, b + s, 1, 0);
         host(1, 0, b ^ 27'h1000000, 1, 0);
      end
   endtask
   task automatic t_rom();
      logic [26:0] a;
      for (int w = 0; w < 6; w++) begin
         a = 27'h00C0000 + 27'(w) * 27'h0008000;
         wb(1, `NCR_IDX_ROM_IRQ, 8'hC0 | 8'(1 << w));
         host(1, 0, a + 27'h0007FFF, 0, 0);
         host(1, 0, a ^ 27'h0008000, 1, 0);
         host(1, 1, a, 1, 0);
         wb(1, `NCR_IDX_WR_CTRL, 8'h80);
         host(1, 1, a, 0, 0);
         wb(1, `NCR_IDX_WR_CTRL, 8'h00);
      end
   endtask
   task automatic t_irq();
      wb(1, `NCR_IDX_ROM_IRQ, 8'h00);
      wb(1, `NCR_IDX_IRQ_STATUS, 8'h0F);
      host_u.irqs(1, 1);
      repeat (5) @(posedge clk_sys);
      host_u.irqs(0, 0);
      repeat (5) @(posedge clk_sys);
      chk("irq", 1'b0, irq);
      chk("kbd_irq_out", 1'b1, ko);
      chk("mouse_irq_out", 1'b1, mo);
      wb(1, `NCR_IDX_IRQ_MASK, 8'h02);
      chk("irq", 1'b1, irq);
      rd(`NCR_IDX_IRQ_STATUS, 8'h03);
      wb(1, `NCR_IDX_IRQ_STATUS, 8'h02);
      chk("irq", 1'b0, irq);
      host(0, 0, 27'h0000060, 1, 0);
      chk("kbd_irq_out", 1'b0, ko);
      chk("mouse_irq_out", 1'b0, mo);
      wb(1, `NCR_IDX_ROM_IRQ, 8'hC0);
      host_u.irqs(0, 1);
      repeat (4) @(posedge clk_sys);
      chk("mouse_irq_out", 1'b1, mo);
      host_u.irqs(0, 0);
      repeat (4) @(posedge clk_sys);
      chk("mouse_irq_out", 1'b0, mo);
   endtask
   task automatic finish_test();
      $display("checks %0d, mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   initial begin
      repeat (8) @(posedge clk_sys);
      reset_n <= 1'b1;
      @(posedge clk_sys);
      t_regs();
      t_block2();
      t_rom();
      t_irq();
      finish_test();
   end
   initial begin
      #500000;
      fail_count++;
      finish_test();
   end
endmodule // ncr_decode_tb
`default_nettype wire

// *** test/ncr_host_model.sv ***
// Purpose: Host bus and IRQ source model
// Assumes: Tasks run just after a rising edge
// Notes:   Released address shows its inverse
`timescale 1ns/10ps
`default_nettype none
module ncr_host_model (
   // Clock
   input  wire logic        clk_sys,
   // Host cycle and IRQ sources
   output var  logic        host_cycle_valid = 1'b0,
   output var  logic        host_mem_cycle = 1'b0,
   output var  logic        host_write = 1'b0,
   output var  logic [26:0] host_addr = 27'h0000000,
   output var  logic        kbd_irq = 1'b0,
   output var  logic        mouse_irq = 1'b0
);
   task automatic host_on(logic m, logic w, logic [26:0] a);
      host_cycle_valid <= 1'b1;
      host_mem_cycle <= m;
      host_write <= w;
      host_addr <= a;
   endtask
   // A stale address could decode by luck, so it is inverted
   task automatic host_off();
      host_cycle_valid <= 1'b0;
      host_addr <= ~host_addr;
   endtask
   task automatic irqs(logic k, logic m);
      kbd_irq <= k;
      mouse_irq <= m;
   endtask
endmodule // ncr_host_model
`default_nettype wire
